// ### shared/gki_params.svh
// register offsets, reset values and timing counts for the gpio/keypad irq status block
`ifndef GKI_PARAMS_SVH
`define GKI_PARAMS_SVH
`define GKI_ADDR_W          8
`define GKI_OFF_IRQ_ALLOW   8'h1B
`define GKI_OFF_FLAGS       8'h1C
`define GKI_OFF_POLARITY    8'h1D
`define GKI_OFF_FILTER_OFF  8'h1E
`define GKI_OFF_PULLUP      8'h1F
`define GKI_OFF_DOWN_LO     8'h20
`define GKI_OFF_DOWN_HI     8'h21
`define GKI_OFF_UP_LO       8'h22
`define GKI_OFF_UP_HI       8'h23
`define GKI_OFF_LINE_IN     8'h24
`define GKI_OFF_EVT_STAT    8'h25
`define GKI_OFF_EVT_CLR     8'h26
`define GKI_OFF_EVT_EN      8'h27
`define GKI_RST_BYTE        8'h00
`define GKI_RST_EVT_EN      4'hF
`define GKI_DEBOUNCE_NS     1000
`define GKI_CLK_NS          8
`define GKI_DEBOUNCE_CYC    ((`GKI_DEBOUNCE_NS + `GKI_CLK_NS - 1) / `GKI_CLK_NS)
`endif

// ### shared/gki_pkg.sv
// types shared by the gpio/keypad irq status block
package gki_pkg;
    typedef logic [7:0] gki_byte_t;
    typedef enum logic [1:0] {
        GKI_IDLE,
        GKI_RESP
    } gki_bus_state_t;
endpackage : gki_pkg

// ### src/gki_line_filter.sv
// one gpio input line: three-stage synchroniser plus optional debounce
`timescale 1ns/100ps
`include "gki_params.svh"
module gki_line_filter (
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic en_in,
    input  wire logic pin_in,
    input  wire logic filter_off_in,
    output logic      level_out
);
    logic [2:0] sync_q;
    logic [7:0] cnt_q;
    logic       level_q;

    // three flops; a change counts once stage two and three agree
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync_q <= 3'h7;
        end else if (en_in) begin
            sync_q <= {sync_q[1:0], pin_in};
        end
    end

    // debounce: new level must hold the full count unless filtering is off
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q   <= 8'h00;
            level_q <= 1'b1;
        end else if (en_in) begin
            if (sync_q[1] != sync_q[2] || sync_q[2] == level_q) begin
                cnt_q <= 8'h00;
            end else if (filter_off_in) begin
                level_q <= sync_q[2];           // see RL4
                cnt_q   <= 8'h00;
            end else if (cnt_q == 8'(`GKI_DEBOUNCE_CYC - 1)) begin
                level_q <= sync_q[2];           // see RL4
                cnt_q   <= 8'h00;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    assign level_out = level_q;
endmodule : gki_line_filter

// ### src/gki_flag_bank.sv
// eight sticky flags cleared on one or two reads; a set wins over a clear
`timescale 1ns/100ps
module gki_flag_bank #(
    parameter bit TWO_READS = 1'b0
) (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       en_in,
    input  wire logic [7:0] set_in,
    input  wire logic       read_in,
    output logic [7:0]      flags_out
);
    logic [7:0] flags_q;
    logic [7:0] armed_q;

    // flags set by events; cleared by reads, armed by a first read when two are needed
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flags_q <= 8'h00;
            armed_q <= 8'h00;
        end else if (en_in) begin
            if (read_in) begin
                if (TWO_READS) begin
                    flags_q <= (flags_q & ~armed_q) | set_in;       // see RL2
                    armed_q <= flags_q & ~armed_q & ~set_in;        // see RL2
                end else begin
                    flags_q <= set_in;                              // see RL8
                end
            end else begin
                flags_q <= flags_q | set_in;
                armed_q <= armed_q & ~set_in;
            end
        end
    end

    assign flags_out = flags_q;
endmodule : gki_flag_bank

// ### src/gki_irq_status.sv
// gpio and keypad interrupt status block with avalon-mm register slave
`timescale 1ns/100ps
`include "gki_params.svh"

// Notes on behaviour
// RL1: one sticky flag per gpio line
// RL2: gpio flag clears on second read
// RL3: polarity bit picks low or high trigger
// RL4: debounce bit zero filters, one bypasses
// RL5: pull-up bit one enables pull-up
// RL6: press flags keys A to H
// RL7: press flags keys I to P
// RL8: key flags clear on single read
// RL9: release flags keys A to H
// RL10: only enabled lines drive interrupt; event_irq_out takes gpio hits from every input line
// RL11: release flags keys I to P
// RL12: interrupt held while any flag set; gpio flags of lines not enabled do not hold it
// RL13: host reads gpio twice, keys once
module gki_irq_status (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       clk_en_in,
    input  wire logic [7:0] address,
    input  wire logic       read,
    input  wire logic       write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0] byteenable,
    output logic [31:0]     readdata,
    output logic            waitrequest,
    input  wire logic [7:0] line_pin_in,
    input  wire logic [7:0] line_is_input_in,
    input  wire logic [15:0] key_state_in,
    output logic [7:0]      line_pullup_on_out,
    output logic            host_irq_out_n,
    output logic            event_irq_out
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0]  line_irq_allow_q;
    logic [7:0]  trigger_polarity_q;
    logic [7:0]  filter_off_q;
    logic [7:0]  pullup_on_q;
    logic [7:0]  line_level;
    logic [7:0]  line_hit;
    logic [15:0] key_q;
    logic [15:0] key_down;
    logic [15:0] key_up;
    logic [7:0]  line_irq_flag;
    logic [7:0]  down_lo;
    logic [7:0]  down_hi;
    logic [7:0]  up_lo;
    logic [7:0]  up_hi;
    logic [3:0]  evt_stat_q;
    logic [3:0]  evt_en_q;
    logic [3:0]  evt_set;
    logic [31:0] readdata_q;
    logic        rd_ok;
    logic        wr_ok;
    logic        acc_q;
    gki_pkg::gki_bus_state_t state_q;

    // byte lane 0 write strobe for an offset
    function automatic logic wr_hit(input logic [7:0] off);
        wr_hit = wr_ok && address == off && byteenable[0];
    endfunction : wr_hit

    ////////////////////////////////////////////////////////////////////////////////
    // input conditioning per line
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_line
            gki_line_filter u_filt (
                .clk_in        (clk_in),
                .rst_b_in      (rst_b_in),
                .en_in         (clk_en_in),
                .pin_in        (line_pin_in[g]),
                .filter_off_in (filter_off_q[g]),
                .level_out     (line_level[g])
            );
        end
    endgenerate

    // level trigger: compare filtered input against polarity
    assign line_hit = line_is_input_in & ~(line_level ^ trigger_polarity_q); // see RL3

    // key state is the same-clock scanner output; edges become events
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            key_q <= 16'h0000;
        end else if (clk_en_in) begin
            key_q <= key_state_in;
        end
    end
    assign key_down = key_state_in & ~key_q;
    assign key_up   = ~key_state_in & key_q;

    ////////////////////////////////////////////////////////////////////////////////
    // bus: one wait cycle, answer on the second edge
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= gki_pkg::GKI_IDLE;
        end else if (clk_en_in) begin
            case (state_q)
                gki_pkg::GKI_IDLE: begin
                    if (read || write) begin
                        state_q <= gki_pkg::GKI_RESP;
                    end
                end
                gki_pkg::GKI_RESP: begin
                    state_q <= gki_pkg::GKI_IDLE;
                end
                default: begin
                    state_q <= gki_pkg::GKI_IDLE;
                end
            endcase
        end
    end
    assign acc_q       = state_q == gki_pkg::GKI_RESP;
    // a frozen clock holds the wait so no access completes without effect
    assign waitrequest = (read || write) && !(acc_q && clk_en_in);
    // read side effects at the capture edge: only reported bits are cleared
    assign rd_ok       = clk_en_in && !acc_q && read;
    assign wr_ok       = clk_en_in && acc_q && write;

    ////////////////////////////////////////////////////////////////////////////////
    // flag banks, key A/I at bit 7
    gki_flag_bank #(.TWO_READS(1'b1)) u_gpio_flags (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .en_in     (clk_en_in),
        .set_in    (line_hit),                                  // see RL1
        .read_in   (rd_ok && address == `GKI_OFF_FLAGS),
        .flags_out (line_irq_flag)
    );
    gki_flag_bank u_down_lo (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .en_in     (clk_en_in),
        .set_in    (key_down[15:8]),                            // see RL6
        .read_in   (rd_ok && address == `GKI_OFF_DOWN_LO),
        .flags_out (down_lo)
    );
    gki_flag_bank u_down_hi (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .en_in     (clk_en_in),
        .set_in    (key_down[7:0]),                             // see RL7
        .read_in   (rd_ok && address == `GKI_OFF_DOWN_HI),
        .flags_out (down_hi)
    );
    gki_flag_bank u_up_lo (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .en_in     (clk_en_in),
        .set_in    (key_up[15:8]),                              // see RL9
        .read_in   (rd_ok && address == `GKI_OFF_UP_LO),
        .flags_out (up_lo)
    );
    gki_flag_bank u_up_hi (
        .clk_in    (clk_in),
        .rst_b_in  (rst_b_in),
        .en_in     (clk_en_in),
        .set_in    (key_up[7:0]),                               // see RL11
        .read_in   (rd_ok && address == `GKI_OFF_UP_HI),
        .flags_out (up_hi)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            line_irq_allow_q   <= `GKI_RST_BYTE;
            trigger_polarity_q <= `GKI_RST_BYTE;
            filter_off_q       <= `GKI_RST_BYTE;
            pullup_on_q        <= `GKI_RST_BYTE;
        end else if (clk_en_in) begin
            if (wr_hit(`GKI_OFF_IRQ_ALLOW)) begin
                line_irq_allow_q <= writedata[7:0];
            end
            if (wr_hit(`GKI_OFF_POLARITY)) begin
                trigger_polarity_q <= writedata[7:0];
            end
            if (wr_hit(`GKI_OFF_FILTER_OFF)) begin
                filter_off_q <= writedata[7:0];
            end
            if (wr_hit(`GKI_OFF_PULLUP)) begin
                pullup_on_q <= writedata[7:0];
            end
        end
    end
    assign line_pullup_on_out = pullup_on_q;                    // see RL5

    ////////////////////////////////////////////////////////////////////////////////
    // block event status: gpio, press, release, any-key; write-one clear, set wins
    assign evt_set = {|(key_down | key_up), |key_up, |key_down, |line_hit};
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            evt_stat_q <= 4'h0;
            evt_en_q   <= `GKI_RST_EVT_EN;
        end else if (clk_en_in) begin
            if (wr_hit(`GKI_OFF_EVT_CLR)) begin
                evt_stat_q <= (evt_stat_q & ~writedata[3:0]) | evt_set;
            end else begin
                evt_stat_q <= evt_stat_q | evt_set;
            end
            if (wr_hit(`GKI_OFF_EVT_EN)) begin
                evt_en_q <= writedata[3:0];
            end
        end
    end
    assign event_irq_out = |(evt_stat_q & evt_en_q);

    // host line: low while any enabled gpio flag or any key flag is set
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            host_irq_out_n <= 1'b1;
        end else if (clk_en_in) begin
            host_irq_out_n <= !(|(line_irq_flag & line_irq_allow_q)   // see RL10
                              || |{down_lo, down_hi, up_lo, up_hi});   // see RL12
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data mux; unmapped offsets read zero
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            readdata_q <= 32'h00000000;
        end else if (rd_ok) begin
            if (address == `GKI_OFF_IRQ_ALLOW) begin
                readdata_q <= {24'h000000, line_irq_allow_q};
            end else if (address == `GKI_OFF_FLAGS) begin
                readdata_q <= {24'h000000, line_irq_flag};
            end else if (address == `GKI_OFF_POLARITY) begin
                readdata_q <= {24'h000000, trigger_polarity_q};
            end else if (address == `GKI_OFF_FILTER_OFF) begin
                readdata_q <= {24'h000000, filter_off_q};
            end else if (address == `GKI_OFF_PULLUP) begin
                readdata_q <= {24'h000000, pullup_on_q};
            end else if (address == `GKI_OFF_DOWN_LO) begin
                readdata_q <= {24'h000000, down_lo};
            end else if (address == `GKI_OFF_DOWN_HI) begin
                readdata_q <= {24'h000000, down_hi};
            end else if (address == `GKI_OFF_UP_LO) begin
                readdata_q <= {24'h000000, up_lo};
            end else if (address == `GKI_OFF_UP_HI) begin
                readdata_q <= {24'h000000, up_hi};
            end else if (address == `GKI_OFF_LINE_IN) begin
                readdata_q <= {24'h000000, line_level};
            end else if (address == `GKI_OFF_EVT_STAT) begin
                readdata_q <= {28'h0000000, evt_stat_q};
            end else if (address == `GKI_OFF_EVT_EN) begin
                readdata_q <= {28'h0000000, evt_en_q};
            end else begin
                readdata_q <= 32'h00000000;
            end
        end
    end
    assign readdata = readdata_q;
endmodule : gki_irq_status

// ### bench/gki_irq_status_chk.sv
// concurrent checks on the irq status block ports
`timescale 1ns/100ps
module gki_irq_status_chk (
    input wire logic        clk_in,
    input wire logic        rst_b_in,
    input wire logic        clk_en_in,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic [7:0]  line_pin_in,
    input wire logic [7:0]  line_is_input_in,
    input wire logic [15:0] key_state_in,
    input wire logic [7:0]  line_pullup_on_out,
    input wire logic        host_irq_out_n,
    input wire logic        event_irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    logic done;
    // a bus access completes this cycle
    assign done = (read || write) && !waitrequest;
    property p_wait;
        (read || write) && waitrequest && clk_en_in |=> !waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("wait lasted over one cycle");
    property p_idle;
        !(read || write) |-> !waitrequest;
    endproperty
    a_idle: assert property (p_idle) else $error("wait raised while idle");
    property p_upper;
        read && !waitrequest |-> readdata[31:8] == 24'h000000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bytes not zero");
    property p_unmap;
        read && waitrequest && (address < 8'h1B || address > 8'h27) |=> readdata == 32'h00000000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_stand;
        !(read && waitrequest) |=> $stable(readdata);
    endproperty
    a_stand: assert property (p_stand) else $error("read data moved");
    property p_pull;
        write && !waitrequest && address == 8'h1F && byteenable[0]
            |=> line_pullup_on_out == $past(writedata[7:0]);
    endproperty
    a_pull: assert property (p_pull) else $error("pull-up enables wrong");
    property p_key;
        clk_en_in && key_state_in != $past(key_state_in) ##1 clk_en_in
            |-> ##[0:2] !host_irq_out_n;
    endproperty
    a_key: assert property (p_key) else $error("key event gave no irq");
    property p_rel;
        $rose(host_irq_out_n) |-> $past(done, 1) || $past(done, 2) || $past(done, 3);
    endproperty
    a_rel: assert property (p_rel) else $error("irq released with no access");
    property p_emask;
        done && write && address == 8'h27 && byteenable[0] && writedata[3:0] == 4'h0
            |=> !event_irq_out;
    endproperty
    a_emask: assert property (p_emask) else $error("masked event irq high");
endmodule : gki_irq_status_chk
bind gki_irq_status gki_irq_status_chk u_chk (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en_in), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .line_pin_in(line_pin_in),
    .line_is_input_in(line_is_input_in), .key_state_in(key_state_in),
    .line_pullup_on_out(line_pullup_on_out), .host_irq_out_n(host_irq_out_n),
    .event_irq_out(event_irq_out)
);

// ### bench/gki_pin_env.sv
// pin world model: drivers, pull-ups and floating lines
`timescale 1ns/100ps
module gki_pin_env (
    input  wire logic       clk_in,
    input  wire logic [7:0] drive_en_in,
    input  wire logic [7:0] drive_val_in,
    input  wire logic [7:0] pullup_in,
    output logic [7:0]      pin_out
);
    logic [7:0] last_q = 8'hFF;
    // remember the last driven level of each line
    always_ff @(posedge clk_in) begin
        last_q <= (drive_en_in & drive_val_in) | (~drive_en_in & last_q);
    end
    // driven lines win, then the pull-up, else a released line shows the inverse
    always_comb begin
        pin_out = (drive_en_in & drive_val_in) | (~drive_en_in & (pullup_in | ~last_q));
    end
endmodule : gki_pin_env

// ### bench/gki_irq_status_test.sv
// self-checking bench for the irq status block
`timescale 1ns/100ps
`include "gki_params.svh"
module gki_irq_status_test;
    localparam int DB = `GKI_DEBOUNCE_CYC;
    logic        clk_in     = 1'b0;
    logic        rst_b_in   = 1'b0;
    logic [7:0]  address    = 8'h00;
    logic        read       = 1'b0;
    logic        write      = 1'b0;
    logic [31:0] writedata  = 32'h00000000;
    logic [3:0]  byteenable = 4'hF;
    logic        cke        = 1'b1;
    logic [7:0]  is_in      = 8'hFF;
    logic [15:0] keys       = 16'h0000;
    logic [7:0]  drv_en     = 8'hFF;
    logic [7:0]  drv_val    = 8'hFF;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        irq_n;
    logic        evt;
    logic [7:0]  pins;
    logic [7:0]  pull;
    logic [7:0]  rd;
    logic [15:0] m;
    int          failures    = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    always #4 clk_in = !clk_in;
    gki_irq_status dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(cke),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .line_pin_in(pins), .line_is_input_in(is_in), .key_state_in(keys),
        .line_pullup_on_out(pull), .host_irq_out_n(irq_n), .event_irq_out(evt));
    gki_pin_env env (.clk_in(clk_in), .drive_en_in(drv_en), .drive_val_in(drv_val),
        .pullup_in(pull), .pin_out(pins));
    ////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wt(input int n);
        repeat (n) @(posedge clk_in);
    endtask : wt
    // request held until waitrequest is sampled low
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge clk_in);
        address <= a;
        writedata <= {24'h000000, d};
        byteenable <= be;
        write <= 1'b1;
        do @(posedge clk_in); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask : bus_wr
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        address <= a;
        read <= 1'b1;
        do @(posedge clk_in); while (waitrequest !== 1'b0);
        rd = readdata[7:0];
        read <= 1'b0;
        check(rd, exp);
    endtask : rc
    // cycle ceiling against hangs
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 30000) begin
            $display("Error at %0t: cycle limit reached", $time);
            failures++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        wt(3);
        rst_b_in <= 1'b1;
        for (int a = 8'h1B; a <= 8'h27; a++) begin
            if (a != 8'h26) begin
                rc(8'(a), a == 8'h24 ? 8'hFF : (a == 8'h27 ? 8'h0F : 8'h00));
            end
        end
        check(pull, 8'h00);
        check({7'h00, irq_n}, 8'h01);
        $display("test reset done");
        bus_wr(8'h1D, 8'hAA, 4'h0);
        rc(8'h1D, 8'h00);
        bus_wr(8'h40, 8'h55, 4'hF);
        rc(8'h40, 8'h00);
        bus_wr(8'h1C, 8'hFF, 4'hF);
        rc(8'h1C, 8'h00);
        for (int a = 8'h1B; a <= 8'h1F; a++) begin
            if (a != 8'h1C) begin
                bus_wr(8'(a), 8'(a) ^ 8'hA5, 4'hF);
                rc(8'(a), 8'(a) ^ 8'hA5);
                if (a == 8'h1F) check(pull, 8'hBA);
                bus_wr(8'(a), 8'h00, 4'h1);
            end
        end
        // polarity pattern above tripped lines 7, 5, 4 and 3
        rc(8'h1C, 8'hB8);
        rc(8'h1C, 8'hB8);
        $display("test access done");
        // line 7 driven low, ignored as output, then trips as input
        bus_wr(8'h1E, 8'hFF, 4'h1);
        is_in <= 8'h7F;
        drv_val <= 8'h7F;
        wt(10);
        rc(8'h1C, 8'h00);
        is_in <= 8'hFF;
        wt(10);
        rc(8'h1C, 8'h80);
        check({7'h00, irq_n}, 8'h01);
        bus_wr(8'h1B, 8'h80, 4'h1);
        wt(3);
        check({7'h00, irq_n}, 8'h00);
        drv_val <= 8'hFF;
        wt(10);
        rc(8'h1C, 8'h80);
        rc(8'h1C, 8'h80);
        rc(8'h1C, 8'h00);
        wt(3);
        check({7'h00, irq_n}, 8'h01);
        bus_wr(8'h1D, 8'h01, 4'h1);
        wt(10);
        rc(8'h1C, 8'h01);
        check({7'h00, irq_n}, 8'h01);
        bus_wr(8'h1D, 8'h00, 4'h1);
        wt(10);
        rc(8'h1C, 8'h01);
        rc(8'h1C, 8'h01);
        rc(8'h1C, 8'h00);
        $display("test trigger done");
        // short glitch on line 1 is filtered, a long low is kept
        bus_wr(8'h1E, 8'hFD, 4'h1);
        drv_val <= 8'hFD;
        wt(DB / 2);
        drv_val <= 8'hFF;
        wt(10);
        rc(8'h1C, 8'h00);
        drv_val <= 8'hFD;
        wt(DB + 20);
        drv_val <= 8'hFF;
        wt(DB + 20);
        rc(8'h1C, 8'h02);
        rc(8'h1C, 8'h02);
        rc(8'h1C, 8'h00);
        // line 2 floats: held by the pull-up, trips without it
        bus_wr(8'h1F, 8'h04, 4'h1);
        drv_en <= 8'hFB;
        wt(10);
        rc(8'h24, 8'hFF);
        rc(8'h1C, 8'h00);
        bus_wr(8'h1F, 8'h00, 4'h1);
        wt(10);
        drv_en <= 8'hFF;
        wt(10);
        rc(8'h1C, 8'h04);
        rc(8'h1C, 8'h04);
        rc(8'h1C, 8'h00);
        $display("test filter done");
        for (int k = 0; k < 16; k++) begin
            m = 16'h8000 >> k;
            keys <= m;
            wt(3);
            check({7'h00, irq_n}, 8'h00);
            rc(8'h20, m[15:8]);
            rc(8'h21, m[7:0]);
            rc(8'h20, 8'h00);
            rc(8'h21, 8'h00);
            keys <= 16'h0000;
            wt(3);
            rc(8'h22, m[15:8]);
            rc(8'h23, m[7:0]);
            rc(8'h22, 8'h00);
            rc(8'h23, 8'h00);
            wt(3);
            check({7'h00, irq_n}, 8'h01);
        end
        $display("test keys done");
        // clock enable low freezes key sampling and the irq line
        cke <= 1'b0;
        wt(1);
        keys <= 16'h0100;
        wt(5);
        check({7'h00, irq_n}, 8'h01);
        cke <= 1'b1;
        wt(3);
        check({7'h00, irq_n}, 8'h00);
        rc(8'h20, 8'h01);
        keys <= 16'h0000;
        wt(3);
        rc(8'h22, 8'h01);
        $display("test freeze done");
        bus_wr(8'h26, 8'h0F, 4'h1);
        wt(1);
        check({7'h00, evt}, 8'h00);
        keys <= 16'h0001;
        wt(3);
        check({7'h00, evt}, 8'h01);
        bus_wr(8'h27, 8'h00, 4'h1);
        wt(1);
        check({7'h00, evt}, 8'h00);
        bus_wr(8'h27, 8'h0F, 4'h1);
        wt(1);
        check({7'h00, evt}, 8'h01);
        keys <= 16'h0000;
        wt(3);
        rc(8'h21, 8'h01);
        rc(8'h23, 8'h01);
        bus_wr(8'h26, 8'h0F, 4'h1);
        wt(1);
        check({7'h00, evt}, 8'h00);
        $display("test events done");
        close_out();
    end
endmodule : gki_irq_status_test
